/* hcfs_clk_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Far-side clocks; a stopped one freezes at its level
module hcfs_clk_model (
    // Run enables
    input wire logic [3:0] run,
    // Clocks
    output var logic [3:0] clk_out
);
    // Host bus clock at 12.5 MHz, inside its allowed span
    for (genvar i = 0; i < 4; i++) begin : g_src
        initial begin
            clk_out[i] = 1'b0;
            forever #(40 + 10 * i) if (run[i]) clk_out[i] = ~clk_out[i];
        end
    end
endmodule
`default_nettype wire

/* hcfs_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
// Ties supervisor outputs to their causes
module hcfs_monitor
    import hcfs_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Watched signals
    input wire logic host_reinit,
    input wire logic dma_active,
    input wire logic [3:0] clock_valid,
    input wire logic [3:0] clock_substituted,
    input wire hcfs_pkg::hcfs_ctrl_s ctrl,
    input wire logic [31:0] data_out,
    input wire logic [3:0] parity_out
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // Four quiet cycles cover the two reinit sync stages
    property p_par; parity_out == ~{^data_out[31:24], ^data_out[23:16],
        ^data_out[15:8], ^data_out[7:0]}; endproperty
    property p_abt; ctrl.dma_abort |-> !clock_valid[0] && $past(dma_active); endproperty
    property p_host; $fell(clock_valid[0]) |-> ctrl.slow_mode; endproperty
    property p_lpr; ctrl.slow_mode == ctrl.low_power_reset; endproperty
    property p_drn; $rose(ctrl.slow_mode) && clock_valid[0] |-> !$past(dma_active); endproperty
    property p_why; $rose(ctrl.slow_mode) |-> clock_valid != 4'hF; endproperty
    property p_sub; $rose(ctrl.slow_mode) |=> clock_substituted == ~clock_valid; endproperty
    property p_hold; (ctrl.slow_mode && !host_reinit) [*4] |=> ctrl.slow_mode; endproperty
    a_par: assert property (p_par) else $error("parity");
    a_abt: assert property (p_abt) else $error("abort");
    a_host: assert property (p_host) else $error("host fail");
    a_lpr: assert property (p_lpr) else $error("low power");
    a_drn: assert property (p_drn) else $error("drain");
    a_why: assert property (p_why) else $error("cause");
    a_sub: assert property (p_sub) else $error("subst");
    a_hold: assert property (p_hold) else $error("hold");
    c_abt: cover property (ctrl.dma_abort);
    c_in: cover property ($rose(ctrl.slow_mode));
    c_out: cover property ($fell(ctrl.slow_mode));
endmodule
`default_nettype wire

/* hcfs_pkg.sv */
package hcfs_pkg;
    // Clock rates
    localparam int CORE_CLK_HZ = 100_000_000;
    localparam int REF_TIMER_HZ = 10_000;
    // Reference timer period in core cycles
    localparam int REF_PERIOD_CYC = CORE_CLK_HZ / REF_TIMER_HZ;
    localparam int REF_CNT_W = 14;
    // Substitute slow clock half period in core cycles
    localparam int SLOW_HALF_CYC = 500;
    localparam int SLOW_CNT_W = 9;
    // Monitored clock indices
    localparam int NUM_CLK = 4;
    localparam int IDX_HOST_BUS = 0;
    localparam int IDX_OSC = 1;
    localparam int IDX_RX = 2;
    localparam int IDX_RING = 3;
    // Data width for parity
    localparam int DATA_BYTES = 4;

    typedef enum logic [1:0] {
        HCFS_RUN = 2'b00,
        HCFS_DRAIN = 2'b01,
        HCFS_SLOW = 2'b10
    } hcfs_state_e;

    typedef struct packed {
        logic dma_abort;
        logic slow_mode;
        logic low_power_reset;
    } hcfs_ctrl_s;
endpackage

/* hcfs_supervisor.sv */
`timescale 1ns/100ps
`default_nettype none
module hcfs_supervisor
    import hcfs_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Monitored clocks, asynchronous
    input wire logic host_bus_clock,
    input wire logic oscillator_clock_in,
    input wire logic recovered_rx_clock,
    input wire logic ring_reference_clock,
    // Host reinitialisation request and DMA status
    input wire logic host_reinit,
    input wire logic dma_active,
    // Internal data to protect
    input wire logic [8*hcfs_pkg::DATA_BYTES-1:0] data_in,
    // Supervisor outputs
    output logic [hcfs_pkg::NUM_CLK-1:0] clock_valid,
    output logic [hcfs_pkg::NUM_CLK-1:0] clock_substituted,
    output logic [hcfs_pkg::NUM_CLK-1:0] clock_out,
    output hcfs_pkg::hcfs_ctrl_s ctrl,
    output logic [8*hcfs_pkg::DATA_BYTES-1:0] data_out,
    output logic [hcfs_pkg::DATA_BYTES-1:0] parity_out
);
    import hcfs_pkg::*;

    // Odd parity for one byte
    function automatic logic odd_par(input logic [7:0] b);
        return ~(^b);
    endfunction

    // True when every monitored clock was seen in the last period
    function automatic logic all_valid(input logic [NUM_CLK-1:0] v);
        return &v;
    endfunction

    logic [NUM_CLK-1:0] clk_raw;
    logic [NUM_CLK-1:0] sync1, sync2, sync3;
    logic [NUM_CLK-1:0] next_sync1, next_sync2;
    logic [NUM_CLK-1:0] next_sync3;
    logic [NUM_CLK-1:0] seen, next_seen;
    logic [NUM_CLK-1:0] valid, next_valid;
    logic [REF_CNT_W-1:0] ref_cnt, next_ref_cnt;
    logic [SLOW_CNT_W-1:0] slow_cnt, next_slow_cnt;
    logic slow_clk, next_slow_clk;
    logic reinit_s1, reinit_s2;
    logic next_reinit_s1, next_reinit_s2;
    hcfs_state_e state, next_state;
    logic [NUM_CLK-1:0] next_clock_valid, next_subst, next_clock_out;
    hcfs_ctrl_s next_ctrl;
    logic [8*DATA_BYTES-1:0] next_data_out;
    logic [DATA_BYTES-1:0] next_parity;

    assign clk_raw = {ring_reference_clock, recovered_rx_clock,
                      oscillator_clock_in, host_bus_clock};

    // Synchroniser stages only shift; only the second stage reads the first stage
    always_comb begin
        next_sync1 = clk_raw;
        next_sync2 = sync1;
        next_reinit_s1 = host_reinit;
        next_reinit_s2 = reinit_s1;
    end

    // Two-stage synchronisers; clocks up to 33 MHz are sampled at 100 MHz
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sync1 <= '0;
            sync2 <= '0;
            reinit_s1 <= 1'b0;
            reinit_s2 <= 1'b0;
        end else begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            reinit_s1 <= next_reinit_s1;
            reinit_s2 <= next_reinit_s2;
        end
    end

    // Activity detection over each reference period
    always_comb begin
        next_sync3 = sync2;
        next_ref_cnt = ref_cnt + 1'b1;
        // Each level of a 33 MHz clock outlasts one core cycle, so no edge is lost
        next_seen = seen | (sync2 ^ sync3);
        next_valid = valid;
        if (ref_cnt == REF_CNT_W'(REF_PERIOD_CYC - 1)) begin
            next_ref_cnt = '0;
            next_valid = next_seen;
            next_seen = '0;
        end
    end

    // Substitute free-running slow clock
    always_comb begin
        next_slow_cnt = slow_cnt + 1'b1;
        next_slow_clk = slow_clk;
        if (slow_cnt == SLOW_CNT_W'(SLOW_HALF_CYC - 1)) begin
            next_slow_cnt = '0;
            next_slow_clk = ~slow_clk;
        end
    end

    // Failure sequencing; slow mode is left only by a host reinit
    always_comb begin
        next_state = state;
        next_ctrl = ctrl;
        next_ctrl.dma_abort = 1'b0;
        case (state)
            HCFS_RUN: begin
                if (!valid[IDX_HOST_BUS]) begin
                    next_ctrl.dma_abort = dma_active;
                    next_state = HCFS_SLOW;
                end else if (!all_valid(valid)) begin
                    next_state = dma_active ? HCFS_DRAIN : HCFS_SLOW;
                end
            end
            HCFS_DRAIN: begin
                // Host bus clock dying mid-drain upgrades to an abort
                if (!valid[IDX_HOST_BUS]) begin
                    next_ctrl.dma_abort = dma_active;
                    next_state = HCFS_SLOW;
                end else if (!dma_active) begin
                    next_state = HCFS_SLOW;
                end
            end
            HCFS_SLOW: begin
                // Reinit honoured only once every clock is back
                if (reinit_s2 && all_valid(valid)) begin
                    next_state = HCFS_RUN;
                end
            end
            default: next_state = HCFS_RUN;
        endcase
        next_ctrl.slow_mode = (next_state == HCFS_SLOW);
        next_ctrl.low_power_reset = (next_state == HCFS_SLOW);
    end

    // Output clock mux and parity generation
    always_comb begin
        next_clock_valid = valid;
        next_subst = '0;
        next_clock_out = sync2;
        if (state == HCFS_SLOW) begin
            next_subst = ~valid;
            for (int i = 0; i < NUM_CLK; i++) begin
                if (!valid[i]) begin
                    next_clock_out[i] = slow_clk;
                end
            end
        end
        next_data_out = data_in;
        for (int b = 0; b < DATA_BYTES; b++) begin
            next_parity[b] = odd_par(data_in[8*b +: 8]);
        end
    end

    // Activity detection state; all clocks count as valid until a full period
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sync3 <= '0;
            seen <= '0;
            valid <= '1;
            ref_cnt <= '0;
        end else begin
            sync3 <= next_sync3;
            seen <= next_seen;
            valid <= next_valid;
            ref_cnt <= next_ref_cnt;
        end
    end

    // Slow clock runs always, so a substitute is ready the moment it is needed
    always_ff @(posedge core_clk) begin
        if (reset) begin
            slow_cnt <= '0;
            slow_clk <= 1'b0;
        end else begin
            slow_cnt <= next_slow_cnt;
            slow_clk <= next_slow_clk;
        end
    end

    // Sequencer state and control levels
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state <= HCFS_RUN;
            ctrl <= '0;
        end else begin
            state <= next_state;
            ctrl <= next_ctrl;
        end
    end

    // Registered outputs; parity of all-zero data is all ones
    always_ff @(posedge core_clk) begin
        if (reset) begin
            clock_valid <= '1;
            clock_substituted <= '0;
            clock_out <= '0;
            data_out <= '0;
            parity_out <= '1;
        end else begin
            clock_valid <= next_clock_valid;
            clock_substituted <= next_subst;
            clock_out <= next_clock_out;
            data_out <= next_data_out;
            parity_out <= next_parity;
        end
    end
endmodule
`default_nettype wire

/* hcfs_supervisor_bench.sv */
`timescale 1ns/100ps
`default_nettype none
// Clock loss, drain, abort and recovery
module hcfs_supervisor_bench;
    import hcfs_pkg::*;
    logic core_clk, reset, host_reinit, dma_active;
    logic [3:0] run, m, clock_valid, clock_substituted, clock_out, parity_out;
    logic [31:0] data_in, data_out;
    hcfs_ctrl_s ctrl;
    int n_mismatch = 0;
    int total_checks = 0;
    hcfs_clk_model hcfs_clk_model_i (.run, .clk_out(m));
    hcfs_supervisor hcfs_supervisor_i (.core_clk, .reset, .host_bus_clock(m[0]),
        .oscillator_clock_in(m[1]), .recovered_rx_clock(m[2]), .ring_reference_clock(m[3]),
        .host_reinit, .dma_active, .data_in, .clock_valid, .clock_substituted,
        .clock_out, .ctrl, .data_out, .parity_out);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // Up to two reference periods pass before a change shows
    task automatic wait_valid(input logic [3:0] w);
        for (int n = 0; n < 25000 && clock_valid !== w; n++) tick(1);
        chk(clock_valid, w);
    endtask
    task automatic recover(input int i);
        logic v;
        v = clock_out[i];
        for (int n = 0; n < 600 && clock_out[i] === v; n++) tick(1);
        chk({3'b0, clock_out[i] !== v}, 4'h1);
        run[i] = 1'b1;
        wait_valid(4'hF);
        tick(5);
        chk({1'b0, ctrl}, 4'h3);
        host_reinit = 1'b1;
        tick(5);
        chk({1'b0, ctrl}, 4'h0);
        chk(clock_substituted, 4'h0);
        host_reinit = 1'b0;
        tick(5);
    endtask
    task automatic t_drain();
        dma_active = 1'b1;
        run[1] = 1'b0;
        wait_valid(4'hD);
        tick(3);
        chk({1'b0, ctrl}, 4'h0);
        chk(clock_substituted, 4'h0);
        dma_active = 1'b0;
        tick(2);
        chk({1'b0, ctrl}, 4'h3);
        chk(clock_substituted, 4'h2);
        recover(1);
    endtask
    task automatic t_abort();
        dma_active = 1'b1;
        run[0] = 1'b0;
        for (int n = 0; n < 25000 && clock_valid[0] !== 1'b0; n++) tick(1);
        chk({1'b0, ctrl}, 4'h7);
        tick(1);
        chk({1'b0, ctrl}, 4'h3);
        chk(clock_substituted, 4'h1);
        dma_active = 1'b0;
        recover(0);
    endtask
    // Data passes one cycle late with odd parity per byte
    task automatic t_parity();
        data_in = 32'h010307FF;
        tick(2);
        chk(parity_out, 4'h5);
        chk(data_out, 32'h010307FF);
        data_in = 32'h80FE0000;
        tick(2);
        chk(parity_out, 4'h3);
        chk(data_out, 32'h80FE0000);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Core clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Hang guard at 10 reference periods, above the few the test needs
    initial begin
        #1_000_000;
        n_mismatch++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        reset = 1'b1;
        host_reinit = 1'b0;
        dma_active = 1'b0;
        run = 4'hF;
        data_in = 32'h0;
        tick(6);
        reset = 1'b0;
        chk(clock_valid, 4'hF);
        t_parity();
        t_drain();
        t_abort();
        tally_and_finish();
    end
endmodule
bind hcfs_supervisor hcfs_monitor hcfs_monitor_i (.core_clk(core_clk), .reset(reset),
    .host_reinit(host_reinit), .dma_active(dma_active), .clock_valid(clock_valid),
    .clock_substituted(clock_substituted), .ctrl(ctrl), .data_out(data_out),
    .parity_out(parity_out));
`default_nettype wire
